// >>> rtl/udfc_pkg.sv
// Purpose: shared constants and types for the uart dma gating and soft flow block
// Assumes: 32-bit register port, byte addresses
// Notes: status/mask offsets are local additions; clears are written to the status offset
package udfc_pkg;
   localparam logic [7:0] OFS_DMA_CTRL = 8'h48;
   localparam logic [7:0] OFS_FLOW_CFG = 8'h50;
   localparam logic [7:0] OFS_RESUME1 = 8'h54;
   localparam logic [7:0] OFS_RESUME2 = 8'h58;
   localparam logic [7:0] OFS_PAUSE1 = 8'h5C;
   localparam logic [7:0] OFS_PAUSE2 = 8'h60;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h64;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h68;
   localparam int BIT_RX_DMA = 0;
   localparam int BIT_TX_DMA = 1;
   localparam int BIT_DMA_BLOCK_ERR = 3;
   localparam int BIT_SOFT_FLOW = 0;
   localparam int BIT_RX_MODE_LO = 1;
   localparam int BIT_TX_MODE_LO = 3;
   localparam int BIT_RESUME_ANY = 5;
   localparam int BIT_SPECIAL = 6;
   localparam int IRQ_PAUSE = 0;
   localparam int IRQ_RESUME = 1;
   localparam int IRQ_SPECIAL = 2;
   localparam int IRQ_W = 3;
   localparam logic [3:0] DMA_CTRL_RESET = 4'h0;
   localparam logic [6:0] FLOW_CFG_RESET = 7'h00;
   localparam logic [7:0] CHAR_RESET = 8'h00;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_PAIR1 = 2'h1;
   localparam logic [1:0] MODE_PAIR2 = 2'h2;
   localparam logic [1:0] MODE_BOTH = 2'h3;

   typedef struct packed {
      logic [3:0] dma;
      logic [6:0] flow;
      logic [7:0] resume1;
      logic [7:0] resume2;
      logic [7:0] pause1;
      logic [7:0] pause2;
   } udfc_cfg_t;

   typedef struct packed {
      logic is_pause;
      logic is_resume;
      logic is_any;
   } udfc_match_t;

   typedef enum logic [1:0] {
      UDFC_RUN = 2'b01,
      UDFC_HOLD = 2'b10
   } udfc_tx_state_t;
endpackage : udfc_pkg

// >>> rtl/udfc_char_match.sv
// Purpose: classify one received character against the programmed pairs
// Assumes: combinational, same clock as its user
// Notes: mode picks pair one, pair two or both
module udfc_char_match (
   input wire logic [1:0] mode, // pair selection
   input wire logic resume_any, // any char resumes
   input wire logic [7:0] ch, // character
   input wire udfc_pkg::udfc_cfg_t cfg, // programmed characters
   output udfc_pkg::udfc_match_t match // classification
);
   logic use1;
   logic use2;
   always_comb begin
      use1 = (mode == udfc_pkg::MODE_PAIR1) || (mode == udfc_pkg::MODE_BOTH);
      use2 = (mode == udfc_pkg::MODE_PAIR2) || (mode == udfc_pkg::MODE_BOTH);
      match.is_pause = (use1 && ch == cfg.pause1) || (use2 && ch == cfg.pause2);
      match.is_resume = resume_any || (use1 && ch == cfg.resume1) || (use2 && ch == cfg.resume2);
      match.is_any = use1 || use2;
   end
endmodule : udfc_char_match

// >>> rtl/udfc_regs.sv
// Purpose: register file of the block on a plain strobe port
// Assumes: strobes one cycle long, never together
// Notes: read data valid the cycle after the read strobe
module udfc_regs (
   input wire logic clk, // clock
   input wire logic nrst, // async reset, low
   input wire logic [7:0] addr, // byte address
   input wire logic [31:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   input wire logic [udfc_pkg::IRQ_W-1:0] irq_status, // sticky status
   output logic [31:0] rdata, // read data
   output udfc_pkg::udfc_cfg_t cfg, // configuration
   output logic [udfc_pkg::IRQ_W-1:0] irq_mask, // mask
   output logic [udfc_pkg::IRQ_W-1:0] irq_clear // write-one-clear pulses
);
   udfc_pkg::udfc_cfg_t cfg_q, cfg_d;
   logic [udfc_pkg::IRQ_W-1:0] mask_q, mask_d;
   logic [31:0] rdata_q, rdata_d;
   always_comb begin
      cfg_d = cfg_q;
      mask_d = mask_q;
      irq_clear = '0;
      rdata_d = 32'h0;
      if (wr) begin
         // reserved bits are dropped on write and read back as zero
         if (addr == udfc_pkg::OFS_DMA_CTRL) begin
            cfg_d.dma = {wdata[3], 1'b0, wdata[1:0]};
         end else if (addr == udfc_pkg::OFS_FLOW_CFG) begin
            cfg_d.flow = wdata[6:0];
         end else if (addr == udfc_pkg::OFS_RESUME1) begin
            cfg_d.resume1 = wdata[7:0];
         end else if (addr == udfc_pkg::OFS_RESUME2) begin
            cfg_d.resume2 = wdata[7:0];
         end else if (addr == udfc_pkg::OFS_PAUSE1) begin
            cfg_d.pause1 = wdata[7:0];
         end else if (addr == udfc_pkg::OFS_PAUSE2) begin
            cfg_d.pause2 = wdata[7:0];
         end else if (addr == udfc_pkg::OFS_IRQ_STATUS) begin
            irq_clear = wdata[udfc_pkg::IRQ_W-1:0];
         end else if (addr == udfc_pkg::OFS_IRQ_MASK) begin
            mask_d = wdata[udfc_pkg::IRQ_W-1:0];
         end
      end
      if (rd) begin
         if (addr == udfc_pkg::OFS_DMA_CTRL) begin
            rdata_d = {28'h0, cfg_q.dma};
         end else if (addr == udfc_pkg::OFS_FLOW_CFG) begin
            rdata_d = {25'h0, cfg_q.flow};
         end else if (addr == udfc_pkg::OFS_RESUME1) begin
            rdata_d = {24'h0, cfg_q.resume1};
         end else if (addr == udfc_pkg::OFS_RESUME2) begin
            rdata_d = {24'h0, cfg_q.resume2};
         end else if (addr == udfc_pkg::OFS_PAUSE1) begin
            rdata_d = {24'h0, cfg_q.pause1};
         end else if (addr == udfc_pkg::OFS_PAUSE2) begin
            rdata_d = {24'h0, cfg_q.pause2};
         end else if (addr == udfc_pkg::OFS_IRQ_STATUS) begin
            rdata_d = {29'h0, irq_status};
         end else if (addr == udfc_pkg::OFS_IRQ_MASK) begin
            rdata_d = {29'h0, mask_q};
         end
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= '{dma: udfc_pkg::DMA_CTRL_RESET, flow: udfc_pkg::FLOW_CFG_RESET,
                    resume1: udfc_pkg::CHAR_RESET, resume2: udfc_pkg::CHAR_RESET,
                    pause1: udfc_pkg::CHAR_RESET, pause2: udfc_pkg::CHAR_RESET};
         mask_q <= '0;
         rdata_q <= 32'h0;
      end else begin
         cfg_q <= cfg_d;
         mask_q <= mask_d;
         rdata_q <= rdata_d;
      end
   end
   assign cfg = cfg_q;
   assign irq_mask = mask_q;
   assign rdata = rdata_q;
endmodule : udfc_regs

// >>> rtl/udfc_top.sv
// Purpose: dma request gating and in-band pause/resume flow control of a uart
// Assumes: character strobes and dma raw requests come from the uart core on clk
// Notes: all outputs registered
// Operation
// - receive dma requests pass only while receive dma enable is set
// - transmit dma requests pass only while transmit dma enable is set
// - with block-on-error set, an asserted error interrupt stops receive dma
// - soft flow enable turns character flow control on or off
// - receive mode picks none, pair one, pair two, or both pairs
// - transmit mode picks none, pair one, pair two, or both pairs
// - resume-on-any makes every received character other than a programmed pause character a resume
// - otherwise only a programmed resume character, or setting transmit mode to none, resumes
// - special character detection works only while its bit is set
// - two 8-bit resume characters, read/write, reset zero
// - two 8-bit pause characters, read/write, reset zero
//
// Design decision made here: the strobed register port.
module udfc_top (
   input wire logic clk, // 25 MHz clock
   input wire logic nrst, // async reset, low
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic rx_char_valid, // received character strobe
   input wire logic [7:0] rx_char, // received character
   input wire logic rx_data_ready, // receive data awaits dma
   input wire logic tx_space_ready, // transmit side wants data
   input wire logic uart_err_irq, // uart error interrupt level
   input wire logic rx_fill_high, // local receive buffer nearly full
   output logic rx_dma_req, // receive dma request
   output logic tx_dma_req, // transmit dma request
   output logic tx_halted, // transmitter paused by far end
   output logic send_pause, // ask transmitter to emit pause char
   output logic send_resume, // ask transmitter to emit resume char
   output logic special_char_seen, // special char strobe
   output logic irq // level interrupt
);
   udfc_pkg::udfc_cfg_t cfg;
   udfc_pkg::udfc_match_t tx_match, rx_match;
   logic [udfc_pkg::IRQ_W-1:0] irq_mask, irq_clear;
   logic [udfc_pkg::IRQ_W-1:0] stat_q, stat_d, ev;
   logic [1:0] tx_mode, rx_mode;
   logic flow_on;
   udfc_pkg::udfc_tx_state_t tx_state_q, tx_state_d;
   logic rx_paused_q, rx_paused_d;
   logic rx_dma_q, rx_dma_d, tx_dma_q, tx_dma_d;
   logic send_pause_q, send_pause_d, send_resume_q, send_resume_d;
   logic special_q, special_d, irq_q, irq_d;
   logic halted_q;

   udfc_regs u_regs (
      .clk(clk),
      .nrst(nrst),
      .addr(reg_addr),
      .wdata(reg_wdata),
      .wr(reg_wr),
      .rd(reg_rd),
      .irq_status(stat_q),
      .rdata(reg_rdata),
      .cfg(cfg),
      .irq_mask(irq_mask),
      .irq_clear(irq_clear)
   );

   always_comb begin
      flow_on = cfg.flow[udfc_pkg::BIT_SOFT_FLOW];
      tx_mode = flow_on ? cfg.flow[udfc_pkg::BIT_TX_MODE_LO +: 2] : udfc_pkg::MODE_OFF;
      rx_mode = flow_on ? cfg.flow[udfc_pkg::BIT_RX_MODE_LO +: 2] : udfc_pkg::MODE_OFF;
   end

   // pairs honoured from the far end for halting our transmitter
   udfc_char_match u_tx_match (
      .mode(tx_mode),
      .resume_any(cfg.flow[udfc_pkg::BIT_RESUME_ANY]),
      .ch(rx_char),
      .cfg(cfg),
      .match(tx_match)
   );

   // pairs we send to pause the far end; special chars use these too
   udfc_char_match u_rx_match (
      .mode(rx_mode),
      .resume_any(1'b0),
      .ch(rx_char),
      .cfg(cfg),
      .match(rx_match)
   );

   // transmit halt state machine
   always_comb begin
      tx_state_d = tx_state_q;
      case (tx_state_q)
         udfc_pkg::UDFC_RUN: begin
            if (rx_char_valid && tx_match.is_any && tx_match.is_pause) begin
               tx_state_d = udfc_pkg::UDFC_HOLD;
            end
         end
         udfc_pkg::UDFC_HOLD: begin
            if (!tx_match.is_any) begin
               tx_state_d = udfc_pkg::UDFC_RUN;
            end else if (rx_char_valid && tx_match.is_resume && !tx_match.is_pause) begin
               tx_state_d = udfc_pkg::UDFC_RUN;
            end
         end
         default: begin
            tx_state_d = udfc_pkg::UDFC_RUN;
         end
      endcase
   end

   // receive side: ask the far end to pause while our buffer is full
   always_comb begin
      rx_paused_d = rx_paused_q;
      send_pause_d = 1'b0;
      send_resume_d = 1'b0;
      if (!rx_match.is_any) begin
         rx_paused_d = 1'b0;
      end else if (rx_fill_high && !rx_paused_q) begin
         rx_paused_d = 1'b1;
         send_pause_d = 1'b1;
      end else if (!rx_fill_high && rx_paused_q) begin
         rx_paused_d = 1'b0;
         send_resume_d = 1'b1;
      end
   end

   // dma gating and events
   always_comb begin
      rx_dma_d = cfg.dma[udfc_pkg::BIT_RX_DMA] && rx_data_ready
                 && !(cfg.dma[udfc_pkg::BIT_DMA_BLOCK_ERR] && uart_err_irq);
      tx_dma_d = cfg.dma[udfc_pkg::BIT_TX_DMA] && tx_space_ready
                 && (tx_state_q == udfc_pkg::UDFC_RUN);
      special_d = rx_char_valid && cfg.flow[udfc_pkg::BIT_SPECIAL]
                  && (tx_match.is_pause || rx_match.is_pause
                      || ((tx_match.is_any || rx_match.is_any) && (rx_char == cfg.resume1 || rx_char == cfg.resume2)));
      ev = '0;
      ev[udfc_pkg::IRQ_PAUSE] = rx_char_valid && tx_match.is_any && tx_match.is_pause;
      ev[udfc_pkg::IRQ_RESUME] = (tx_state_q == udfc_pkg::UDFC_HOLD) && (tx_state_d == udfc_pkg::UDFC_RUN);
      ev[udfc_pkg::IRQ_SPECIAL] = special_d;
      stat_d = (stat_q & ~irq_clear) | ev; // set wins over clear
      irq_d = |(stat_d & irq_mask);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_state_q <= udfc_pkg::UDFC_RUN;
         rx_paused_q <= 1'b0;
         rx_dma_q <= 1'b0;
         tx_dma_q <= 1'b0;
         send_pause_q <= 1'b0;
         send_resume_q <= 1'b0;
         special_q <= 1'b0;
         halted_q <= 1'b0;
         stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         tx_state_q <= tx_state_d;
         rx_paused_q <= rx_paused_d;
         rx_dma_q <= rx_dma_d;
         tx_dma_q <= tx_dma_d;
         send_pause_q <= send_pause_d;
         send_resume_q <= send_resume_d;
         special_q <= special_d;
         halted_q <= (tx_state_d == udfc_pkg::UDFC_HOLD);
         stat_q <= stat_d;
         irq_q <= irq_d;
      end
   end

   assign rx_dma_req = rx_dma_q;
   assign tx_dma_req = tx_dma_q;
   assign tx_halted = halted_q;
   assign send_pause = send_pause_q;
   assign send_resume = send_resume_q;
   assign special_char_seen = special_q;
   assign irq = irq_q;
endmodule : udfc_top

// >>> tb/udfc_assertions.sv
// Purpose: port-level checks of dma gating and soft flow control
// Assumes: single clock, registered outputs one cycle after their cause
// Notes: shadows the dma and flow config writes to judge the gates
module udfc_assertions (
   input wire logic clk, // clock
   input wire logic nrst, // async reset, low
   input wire logic [7:0] reg_addr, // register address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic rx_char_valid, // char strobe
   input wire logic rx_data_ready, // rx data waiting
   input wire logic tx_space_ready, // tx wants data
   input wire logic uart_err_irq, // error level
   input wire logic rx_fill_high, // rx near full
   input wire logic rx_dma_req, // rx request
   input wire logic tx_dma_req, // tx request
   input wire logic tx_halted, // tx paused
   input wire logic send_pause, // pause pulse
   input wire logic send_resume, // resume pulse
   input wire logic special_char_seen // special pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] dma_q, dma_d;
   logic [6:0] flow_q, flow_d;
   always_comb begin
      dma_d = dma_q;
      flow_d = flow_q;
      if (reg_wr && reg_addr == udfc_pkg::OFS_DMA_CTRL) dma_d = reg_wdata[3:0];
      if (reg_wr && reg_addr == udfc_pkg::OFS_FLOW_CFG) flow_d = reg_wdata[6:0];
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dma_q <= 4'h0;
         flow_q <= 7'h00;
      end else begin
         dma_q <= dma_d;
         flow_q <= flow_d;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   rx_dma_gate_a: assert property (rx_dma_req ==
      $past(dma_q[0] && rx_data_ready && !(dma_q[3] && uart_err_irq)))
      else $error("rx dma request wrong");
   tx_dma_gate_a: assert property (tx_dma_req ==
      $past(dma_q[1] && tx_space_ready && !tx_halted))
      else $error("tx dma request wrong");
   halt_cause_a: assert property ($rose(tx_halted) |-> $past(rx_char_valid))
      else $error("halt without char");
   // a mode write takes one edge to land and one more to release the halt
   resume_cause_a: assert property ($fell(tx_halted) |-> $past(rx_char_valid) || $past(reg_wr, 2))
      else $error("resume without cause");
   halt_flow_off_a: assert property ($rose(tx_halted) |-> $past(flow_q[0]))
      else $error("halt while flow off");
   special_gate_a: assert property (special_char_seen |-> $past(rx_char_valid) && $past(flow_q[6]))
      else $error("special char while off");
   pause_edge_a: assert property (send_pause |-> $past(rx_fill_high) && !$past(rx_fill_high, 2))
      else $error("pause pulse without rise");
   resume_edge_a: assert property (send_resume |-> !$past(rx_fill_high) && $past(rx_fill_high, 2))
      else $error("resume pulse without fall");
   cover property ($rose(tx_halted));
   cover property (rx_dma_req && dma_q[3]);
   cover property (send_pause);
   cover property (special_char_seen);
endmodule : udfc_assertions

bind udfc_top udfc_assertions chk_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .rx_char_valid(rx_char_valid), .rx_data_ready(rx_data_ready),
   .tx_space_ready(tx_space_ready), .uart_err_irq(uart_err_irq), .rx_fill_high(rx_fill_high),
   .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .tx_halted(tx_halted), .send_pause(send_pause),
   .send_resume(send_resume), .special_char_seen(special_char_seen));

// >>> tb/udfc_far_end.sv
// Purpose: remote serial device sending characters and honouring flow requests
// Assumes: one character per command, registered
// Notes: idle data line alternates between the last char and its inverse
module udfc_far_end (
   input wire logic clk, // clock
   input wire logic nrst, // async reset, low
   input wire logic cmd_valid, // bench asks to send
   input wire logic [7:0] cmd_char, // char to send
   input wire logic send_pause, // local side asks pause
   input wire logic send_resume, // local side asks resume
   output logic rx_char_valid, // char strobe
   output logic [7:0] rx_char, // char
   output logic paused // remote has stopped sending
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_char_valid <= 1'b0;
         rx_char <= 8'h5A;
         paused <= 1'b0;
      end else begin
         paused <= send_pause ? 1'b1 : (send_resume ? 1'b0 : paused);
         rx_char_valid <= cmd_valid && !paused;
         rx_char <= (cmd_valid && !paused) ? cmd_char : ~rx_char;
      end
   end
endmodule : udfc_far_end

// >>> tb/test_uart_dma_and_soft_flow_ctrl.sv
// Purpose: self-checking bench of dma gating and soft flow control
// Assumes: 25 MHz clock, far end model drives received chars
// Notes: char values drawn from an lfsr with fixed start
module test_uart_dma_and_soft_flow_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, reg_wr, reg_rd, rx_char_valid, rx_data_ready, tx_space_ready, uart_err_irq;
   logic rx_fill_high, rx_dma_req, tx_dma_req, tx_halted, send_pause, send_resume, special_char_seen;
   logic irq, cmd_valid, far_paused;
   logic [7:0] reg_addr, rx_char, cmd_char, b;
   logic [31:0] reg_wdata, reg_rdata, rs;
   logic [7:0] cv [4];
   int err_total, tests_run, scnt;
   udfc_top dut_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .rx_data_ready(rx_data_ready), .tx_space_ready(tx_space_ready), .uart_err_irq(uart_err_irq),
      .rx_fill_high(rx_fill_high), .rx_dma_req(rx_dma_req), .tx_dma_req(tx_dma_req), .tx_halted(tx_halted),
      .send_pause(send_pause), .send_resume(send_resume), .special_char_seen(special_char_seen), .irq(irq));
   udfc_far_end far_u (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_char(cmd_char),
      .send_pause(send_pause), .send_resume(send_resume), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .paused(far_paused));
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function logic exp_rx(input logic [3:0] d, input logic rdy, input logic err);
      return d[0] && rdy && !(d[3] && err);
   endfunction : exp_rx
   task chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata === e, "read data");
   endtask : rd
   task snd(input logic [7:0] c);
      @(posedge clk);
      cmd_valid <= 1'b1; cmd_char <= c;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : snd
   task final_report();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) if (special_char_seen === 1'b1) scnt++;
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      final_report();
   end
   initial begin
      nrst = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; cmd_valid = 1'b0;
      cmd_char = 8'h00; rx_data_ready = 1'b0; tx_space_ready = 1'b0; uart_err_irq = 1'b0; rx_fill_high = 1'b0;
      rs = 32'h0001303B;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      for (int k = 0; k < 8; k++) rd(8'h48 + 8'(k == 0 ? 0 : 4 + 4 * k), 32'h0);
      for (int i = 0; i < 16; i++) begin
         rs = lfsr(rs);
         wr(udfc_pkg::OFS_DMA_CTRL, {28'h0, i[2], 1'b0, i[1], i[0]});
         rx_data_ready <= rs[0]; tx_space_ready <= 1'b1; uart_err_irq <= i[3];
         repeat (3) @(posedge clk);
         #1 chk(rx_dma_req === exp_rx({i[2], 1'b0, i[1], i[0]}, rs[0], i[3]), "rx dma");
         chk(tx_dma_req === i[1], "tx dma");
      end
      wr(udfc_pkg::OFS_DMA_CTRL, 32'h3);
      rs = lfsr(rs);
      b = rs[7:0];
      for (int k = 0; k < 4; k++) begin
         cv[k] = b + 8'(k);
         wr(udfc_pkg::OFS_RESUME1 + 8'(4 * k), {24'h0, cv[k]});
         rd(udfc_pkg::OFS_RESUME1 + 8'(4 * k), {24'h0, cv[k]});
      end
      wr(8'h70, 32'h5);
      rd(8'h70, 32'h0);
      for (int m = 0; m < 4; m++) begin
         wr(udfc_pkg::OFS_FLOW_CFG, 32'h47 | (m << 3));
         snd(cv[2]); chk(tx_halted === m[0], "pause one");
         snd(cv[1]); chk(tx_halted === (m == 1), "resume two");
         snd(cv[0]); chk(tx_halted === 1'b0, "resume one");
         snd(cv[3]); chk(tx_halted === m[1], "pause two");
         snd(cv[1]); chk(tx_halted === 1'b0, "resume two");
      end
      chk(scnt > 0, "special seen");
      wr(udfc_pkg::OFS_FLOW_CFG, 32'h7F);
      snd(cv[3]); chk(tx_halted === 1'b1, "pause any");
      snd(b + 8'h04); chk(tx_halted === 1'b0, "any resumes");
      wr(udfc_pkg::OFS_FLOW_CFG, 32'h1E);
      snd(cv[2]); chk(tx_halted === 1'b0, "flow off");
      wr(udfc_pkg::OFS_FLOW_CFG, 32'h1F);
      scnt = 0;
      snd(cv[2]); chk(tx_halted === 1'b1, "flow on");
      chk(scnt == 0, "special off");
      snd(cv[0]);
      wr(udfc_pkg::OFS_IRQ_MASK, 32'h1);
      #1 chk(irq === 1'b0, "irq masked");
      // irq follows the mask register one edge after the write lands
      @(posedge clk);
      #1 chk(irq === 1'b1, "irq raised");
      rd(udfc_pkg::OFS_IRQ_STATUS, 32'h7);
      wr(udfc_pkg::OFS_IRQ_STATUS, 32'h0);
      rd(udfc_pkg::OFS_IRQ_STATUS, 32'h7);
      wr(udfc_pkg::OFS_IRQ_STATUS, 32'h1);
      rd(udfc_pkg::OFS_IRQ_STATUS, 32'h6);
      chk(irq === 1'b0, "irq cleared");
      for (int m = 0; m < 4; m++) begin
         wr(udfc_pkg::OFS_FLOW_CFG, 32'h1 | (m << 1));
         rx_fill_high <= 1'b1;
         repeat (3) @(posedge clk);
         #1 chk(far_paused === (m != 0), "rx pause");
         rx_fill_high <= 1'b0;
         repeat (3) @(posedge clk);
         #1 chk(far_paused === 1'b0, "rx resume");
      end
      final_report();
   end
endmodule : test_uart_dma_and_soft_flow_ctrl
